// >>> common/pac_pkg.sv
// Purpose: shared constants for the pulse accumulator counter
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   offsets are word indices; addresses are byte addresses
package pac_pkg;
  localparam logic [11:0] PAC_OFF_FLAG   = 12'h0025;
  localparam logic [11:0] PAC_OFF_CTRL   = 12'h0026;
  localparam logic [11:0] PAC_OFF_COUNT  = 12'h0027;
  localparam logic [11:0] PAC_ADDR_FLAG  = 12'h0094;
  localparam logic [11:0] PAC_ADDR_CTRL  = 12'h0098;
  localparam logic [11:0] PAC_ADDR_COUNT = 12'h009C;
  localparam logic [11:0] PAC_ADDR_MASK  = 12'h00A0;
  localparam logic [11:0] PAC_ADDR_IRQ   = 12'h00A4;
  localparam int PAC_BIT_WRAP = 5;
  localparam int PAC_BIT_EDGE = 4;
  localparam int PAC_BIT_EN   = 6;
  localparam int PAC_BIT_MODE = 5;
  localparam int PAC_BIT_POL  = 4;
  localparam logic [7:0] PAC_CTRL_RST = 8'h00;
  localparam logic [7:0] PAC_FLAG_RST = 8'h00;
  localparam logic [7:0] PAC_MASK_RST = 8'h00;
  localparam int PAC_TICK_DIV = 64;
  typedef enum logic [1:0] {
    PAC_IDLE   = 2'b00,
    PAC_ACCESS = 2'b01
  } pac_bus_t;
endpackage

// >>> core/pac_tick.sv
// Purpose: free-running divide-by-n tick for gated time accumulation
// Assumes: ce freezes the divider
// Notes:   tick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module pac_tick #(
  parameter int DIV = 64
) (
  input  wire logic pclk,     // clock
  input  wire logic presetn,  // async reset, low
  input  wire logic ce,       // clock enable
  output logic      tick      // one pulse per DIV cycles
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else if (ce)
    begin
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
      tick  <= (cnt_r == LAST);
    end
  end
endmodule
`default_nettype wire

// >>> core/pac_core.sv
// Purpose: 8-bit pulse accumulator with flags, masks and apb registers
// Assumes: pin input synchronous to pclk; single clock
// Notes:   count register has no reset; reads see registered state only
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE_01] eight-bit count register, readable and writable by software
// [RULE_02] reset leaves the count register untouched
// [RULE_03] count register accessible any time, counting or not
// [RULE_04] increments clocked, reads sample registered value, never mid-change
// [RULE_05] wrap flag sets when count rolls from ff to 00
// [RULE_06] writing one at bit 5 of flag register clears wrap flag
// [RULE_07] wrap flag independent of its enable; zero enable blocks interrupt
// [RULE_08] wrap enable high: interrupt requested when wrap flag set
// [RULE_09] software clears wrap flag before leaving its service routine
// [RULE_10] edge flag sets on each selected input edge; code sets it only while accumulator enable is one
// [RULE_11] writing one at bit 4 of flag register clears edge flag
// [RULE_12] edge flag independent of its enable; zero enable blocks interrupt
// [RULE_13] edge enable high: interrupt requested when edge flag set
// [RULE_14] software clears edge flag before leaving its service routine
// [RULE_15] event mode counts falling edges, or rising when polarity set
// [RULE_16] gated mode counts divide-64 ticks while pin at active level
// [RULE_17] counting only while accumulator enable is one
// [RULE_18] zero writes leave flags; set beats simultaneous clear
// [RULE_19] combined interrupt is or of both masked flags
module pac_core
  import pac_pkg::*;
#(
  parameter int TICK_DIV = pac_pkg::PAC_TICK_DIV
) (
  input  wire logic        pclk,                  // clock, 250 MHz
  input  wire logic        presetn,               // async reset, low
  input  wire logic        ce,                    // clock enable
  input  wire logic        psel,                  // apb select
  input  wire logic        penable,               // apb enable
  input  wire logic        pwrite,                // apb direction
  input  wire logic [11:0] paddr,                 // apb byte address
  input  wire logic [31:0] pwdata,                // apb write data
  input  wire logic [3:0]  pstrb,                 // apb byte strobes
  output logic      [31:0] prdata,                // apb read data
  output logic             pready,                // apb ready
  output logic             pslverr,               // apb error
  input  wire logic        accumulator_input_pin, // event or gate pin
  output logic             acc_irq                // interrupt, high active
);
  import pac_pkg::*;

  // registers
  logic [7:0] pulse_count_reg;  // no reset on purpose
  logic [7:0] ctrl_r;
  logic [7:0] mask_r;
  logic       count_wrap_flag;
  logic       input_edge_flag;
  logic       pin_d_r;
  logic       acc_irq_r;
  logic [7:0] irq_stat_r;
  pac_bus_t   bus_st_r;

  // decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  wire        acc_ph   = psel & penable;
  wire        wr_ph    = acc_ph & pwrite & pstrb[0];
  wire        rd_ph    = acc_ph & ~pwrite;
  wire        sel_flag = hit(paddr, PAC_ADDR_FLAG);
  wire        sel_ctrl = hit(paddr, PAC_ADDR_CTRL);
  wire        sel_cnt  = hit(paddr, PAC_ADDR_COUNT);
  wire        sel_mask = hit(paddr, PAC_ADDR_MASK);
  wire        sel_irq  = hit(paddr, PAC_ADDR_IRQ);
  wire        mapped   = sel_flag | sel_ctrl | sel_cnt | sel_mask | sel_irq;
  wire        bus_go   = psel & ~penable & ce;

  // control fields
  wire accumulator_enable     = ctrl_r[PAC_BIT_EN];
  wire accumulate_mode_select = ctrl_r[PAC_BIT_MODE];
  wire edge_polarity_select   = ctrl_r[PAC_BIT_POL];
  wire count_wrap_irq_enable  = mask_r[PAC_BIT_WRAP];
  wire input_edge_irq_enable  = mask_r[PAC_BIT_EDGE];

  // pin edge detection; pin is already synchronous
  wire rise_ev  = accumulator_input_pin & ~pin_d_r;
  wire fall_ev  = ~accumulator_input_pin & pin_d_r;
  wire sel_edge = edge_polarity_select ? rise_ev : fall_ev;

  // gated mode: polarity zero means low pin inhibits
  wire gate_on = (accumulator_input_pin == edge_polarity_select) ? 1'b0 : 1'b1;

  logic tick;
  pac_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .tick    (tick)
  );

  // increment source
  wire inc_ev   = accumulate_mode_select ? (tick & gate_on) : sel_edge;  // [RULE_15] [RULE_16]
  wire inc      = accumulator_enable & inc_ev;                            // [RULE_17]
  wire wrap_ev  = inc & (pulse_count_reg == 8'hFF);                       // [RULE_05]
  wire edge_ev  = accumulator_enable & sel_edge;                          // [RULE_10]
  wire cnt_wr   = wr_ph & sel_cnt & pready;

  // flag clear by write-one, set wins
  wire wrap_clr = wr_ph & sel_flag & pready & pwdata[PAC_BIT_WRAP];  // [RULE_06]
  wire edge_clr = wr_ph & sel_flag & pready & pwdata[PAC_BIT_EDGE];  // [RULE_11]
  wire wrap_nxt = wrap_ev | (count_wrap_flag & ~wrap_clr);           // [RULE_18]
  wire edge_nxt = edge_ev | (input_edge_flag & ~edge_clr);           // [RULE_18]

  // interrupt, flags do not depend on enables
  wire irq_nxt = (wrap_nxt & count_wrap_irq_enable)
               | (edge_nxt & input_edge_irq_enable);  // [RULE_07] [RULE_08] [RULE_12] [RULE_13] [RULE_19]

  // sticky event status, cleared by reading it
  wire       stat_rd  = rd_ph & sel_irq & pready;
  wire [7:0] stat_set = {2'b00, wrap_ev, edge_ev, 4'h0};
  wire [7:0] stat_nxt = stat_set | (stat_rd ? 8'h00 : irq_stat_r);

  wire [7:0] flag_view = {2'b00, count_wrap_flag, input_edge_flag, 4'h0};
  wire [7:0] rd_byte   = sel_flag ? flag_view :
                         sel_ctrl ? ctrl_r :
                         sel_cnt  ? pulse_count_reg :
                         sel_mask ? mask_r :
                         sel_irq  ? irq_stat_r : 8'h00;

  // count register: software write takes priority over an increment
  // in the same cycle, so the written value is exactly what sticks
  always_ff @(posedge pclk)                      // [RULE_02]
  begin
    if (ce)
    begin
      if (cnt_wr)
        pulse_count_reg <= pwdata[7:0];           // [RULE_01] [RULE_03]
      else if (inc)
        pulse_count_reg <= pulse_count_reg + 8'h01;  // [RULE_04]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r          <= PAC_CTRL_RST;
      mask_r          <= PAC_MASK_RST;
      count_wrap_flag <= 1'b0;
      input_edge_flag <= 1'b0;
      irq_stat_r      <= PAC_FLAG_RST;
      acc_irq_r       <= 1'b0;
      pin_d_r         <= 1'b0;
    end
    else if (ce)
    begin
      count_wrap_flag <= wrap_nxt;
      input_edge_flag <= edge_nxt;
      irq_stat_r      <= stat_nxt;
      acc_irq_r       <= irq_nxt;
      pin_d_r         <= accumulator_input_pin;
      if (wr_ph & sel_ctrl & pready)
        ctrl_r <= pwdata[7:0];
      if (wr_ph & sel_mask & pready)
        mask_r <= pwdata[7:0];
    end
  end

  assign acc_irq = acc_irq_r;

  // apb: no wait states, pready high in the first access cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_st_r <= PAC_IDLE;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
    end
    else if (ce)
    begin
      case (bus_st_r)
        PAC_IDLE:
        begin
          if (bus_go)
          begin
            bus_st_r <= PAC_ACCESS;
            pready   <= 1'b1;
            pslverr  <= ~hit(paddr, PAC_ADDR_FLAG) & ~hit(paddr, PAC_ADDR_CTRL)
                      & ~hit(paddr, PAC_ADDR_COUNT) & ~hit(paddr, PAC_ADDR_MASK)
                      & ~hit(paddr, PAC_ADDR_IRQ);
            prdata   <= {24'h00_0000, rd_byte};   // [RULE_04]
          end
        end
        PAC_ACCESS:
        begin
          bus_st_r <= PAC_IDLE;
          pready   <= 1'b0;
          pslverr  <= 1'b0;
        end
        default:
        begin
          bus_st_r <= PAC_IDLE;
          pready   <= 1'b0;
          pslverr  <= 1'b0;
        end
      endcase
    end
  end

  // count has no reset: checks on its history wait for a first load
  logic cnt_seen_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_seen_r <= 1'b0;
    else if (ce & cnt_wr)
      cnt_seen_r <= 1'b1;
  end

  // mapped is kept for the error check below
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel & penable & pready & ~mapped) |-> pslverr)
    else $error("unmapped access without error");  // [RULE_01]

  a_wrap_sets: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
    (ce & wrap_ev) |=> count_wrap_flag)
    else $error("wrap flag not set on rollover");

  a_wrap_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
    (ce & wrap_clr & ~wrap_ev) |=> !count_wrap_flag)
    else $error("wrap flag not cleared by write one");

  a_edge_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
    (ce & edge_clr & ~edge_ev) |=> !input_edge_flag)
    else $error("edge flag not cleared by write one");

  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_18]
    (ce & edge_ev & edge_clr) |=> input_edge_flag)
    else $error("edge set lost to clear");

  a_edge_sets: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
    (ce & accumulator_enable & ~accumulate_mode_select & ~edge_polarity_select
     & pin_d_r & ~accumulator_input_pin) |=> input_edge_flag)
    else $error("falling edge did not set edge flag");

  a_count_incr: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
    (ce & inc & ~cnt_wr) |=> (pulse_count_reg == $past(pulse_count_reg) + 8'h01))
    else $error("count did not increment");

  a_disabled_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_17]
    (ce & ~accumulator_enable & ~cnt_wr & cnt_seen_r) |=> $stable(pulse_count_reg))
    else $error("count moved while disabled");

  a_irq_mask: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_19]
    ce |=> (acc_irq == ((count_wrap_flag & $past(count_wrap_irq_enable))
                      | (input_edge_flag & $past(input_edge_irq_enable)))))
    else $error("interrupt does not match masked flags");

  a_count_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
    (ce & cnt_wr) |=> (pulse_count_reg == $past(pwdata[7:0])))
    else $error("count write lost");

  a_wrap_wins: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_18]
    (ce & wrap_ev & wrap_clr) |=> count_wrap_flag)
    else $error("wrap set lost to clear");

  a_wrap_zero_wr: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_18]
    (ce & wr_ph & sel_flag & pready & ~pwdata[PAC_BIT_WRAP] & count_wrap_flag)
    |=> count_wrap_flag)
    else $error("zero write cleared wrap flag");

  a_edge_zero_wr: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_18]
    (ce & wr_ph & sel_flag & pready & ~pwdata[PAC_BIT_EDGE] & input_edge_flag)
    |=> input_edge_flag)
    else $error("zero write cleared edge flag");

  a_rise_sets: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
    (ce & accumulator_enable & ~accumulate_mode_select & edge_polarity_select
     & ~pin_d_r & accumulator_input_pin) |=> input_edge_flag)
    else $error("rising edge did not set edge flag");

  a_wrap_polled: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
    (ce & wrap_ev & ~count_wrap_irq_enable) |=> count_wrap_flag)
    else $error("wrap flag needs its enable");

  a_edge_polled: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
    (ce & edge_ev & ~input_edge_irq_enable) |=> input_edge_flag)
    else $error("edge flag needs its enable");

  a_wrap_irq: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_08]
    (ce & wrap_ev & count_wrap_irq_enable) |=> acc_irq)
    else $error("no interrupt on enabled wrap");

  a_edge_irq: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
    (ce & edge_ev & input_edge_irq_enable) |=> acc_irq)
    else $error("no interrupt on enabled edge");

  a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_19]
    (ce & ~count_wrap_irq_enable & ~input_edge_irq_enable) |=> !acc_irq)
    else $error("interrupt with both enables low");

  a_gated_incr: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_16]
    (ce & accumulator_enable & accumulate_mode_select & tick & gate_on & ~cnt_wr)
    |=> (pulse_count_reg == $past(pulse_count_reg) + 8'h01))
    else $error("gated tick did not count");

  a_gated_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_16]
    (ce & accumulator_enable & accumulate_mode_select & ~gate_on & ~cnt_wr & cnt_seen_r)
    |=> $stable(pulse_count_reg))
    else $error("count moved while gate inhibits");

  a_event_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
    (ce & accumulator_enable & ~accumulate_mode_select & ~sel_edge & ~cnt_wr & cnt_seen_r)
    |=> $stable(pulse_count_reg))
    else $error("count moved without selected edge");

  a_rise_incr: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
    (ce & accumulator_enable & ~accumulate_mode_select & edge_polarity_select
     & rise_ev & ~cnt_wr) |=> (pulse_count_reg == $past(pulse_count_reg) + 8'h01))
    else $error("rising edge did not count");

  a_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
    (ce & wrap_ev & ~cnt_wr) |=> (pulse_count_reg == 8'h00))
    else $error("rollover did not reach zero");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
    (ce & pready) |=> !pready)
    else $error("ready held past one cycle");

  a_count_read: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
    (ce & bus_go & sel_cnt & ~pwrite & cnt_seen_r)
    |=> (prdata[7:0] == $past(pulse_count_reg)))
    else $error("count read not the settled value");

  a_no_edge_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_17]
    (ce & ~accumulator_enable & ~input_edge_flag) |=> !input_edge_flag)
    else $error("edge flag set while disabled");

  a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
    (psel & penable & pready & mapped) |-> !pslverr)
    else $error("error on mapped access");

  a_wrap_steady: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
    (ce & ~wrap_ev & ~wrap_clr) |=> (count_wrap_flag == $past(count_wrap_flag)))
    else $error("wrap flag changed without cause");

  a_edge_steady: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
    (ce & ~edge_ev & ~edge_clr) |=> (input_edge_flag == $past(input_edge_flag)))
    else $error("edge flag changed without cause");
endmodule
`default_nettype wire

// >>> verification/pac_pin_model.sv
// Purpose: pin source standing in for the external event or gate
// Assumes: pin changes just after a rising edge
// Notes:   n level changes, one every half+1 cycles
`timescale 1ns/1ps
`default_nettype none
module pac_pin_model (
  input  wire logic       pclk,    // clock
  input  wire logic       presetn, // reset, low
  input  wire logic       go,      // start a burst
  input  wire logic [7:0] n_tgl,   // level changes in burst
  input  wire logic [3:0] half,    // wait between changes
  output logic            pin,     // to accumulator input
  output logic            busy     // burst running
);
  logic [7:0] left_r;
  logic [3:0] tmr_r;
  assign busy = (left_r != 8'h00);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left_r <= 8'h00;
      tmr_r  <= 4'h0;
      pin    <= 1'b0;
    end
    else if (go)
    begin
      left_r <= n_tgl;
      tmr_r  <= half;
    end
    else if (busy && tmr_r == 4'h0)
    begin
      pin    <= ~pin;
      left_r <= left_r - 8'h01;
      tmr_r  <= half;
    end
    else if (busy)
      tmr_r <= tmr_r - 4'h1;
  end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Purpose: self-checking bench for the pulse accumulator
// Assumes: short tick divider; count written before use
// Notes:   apb master holds each request until pready
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pac_pkg::*;
  localparam int TDIV = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        acc_irq;
  logic        go = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  n_tgl = 8'h00;
  logic [3:0]  half = 4'h2;
  logic        busy;
  logic [31:0] rd;
  logic        err;
  int          n_fail = 0;
  int          total_checks = 0;
  always #2 pclk = ~pclk;
  pac_core #(.TICK_DIV(TDIV)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .accumulator_input_pin(pin), .acc_irq(acc_irq));
  pac_pin_model pin_u (.pclk(pclk), .presetn(presetn), .go(go), .n_tgl(n_tgl),
    .half(half), .pin(pin), .busy(busy));
  task automatic results;
  begin
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  // irq is a registered level: look at it mid-cycle, resume on a rising edge
  task automatic chk_irq(input logic exp);
  begin
    @(negedge pclk);
    total_checks++;
    if (acc_irq !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t irq %b want %b", $time, acc_irq, exp);
    end
    @(posedge pclk);
  end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
  begin
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
  begin
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h00_0000, e});
  end
  endtask
  task automatic burst(input logic [7:0] n, input logic [3:0] h);
  begin
    n_tgl <= n;
    half  <= h;
    go    <= 1'b1;
    @(posedge pclk);
    go    <= 1'b0;
    @(posedge pclk);
    while (busy)
      @(posedge pclk);
    repeat (4) @(posedge pclk);
  end
  endtask
  task automatic t_regs;
  begin
    rc(PAC_ADDR_CTRL, PAC_CTRL_RST);
    rc(PAC_ADDR_FLAG, PAC_FLAG_RST);
    rc(PAC_ADDR_MASK, PAC_MASK_RST);
    rc(12'h00F0, 8'h00);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, PAC_ADDR_COUNT, 8'hA5);
    rc(PAC_ADDR_COUNT, 8'hA5);
  end
  endtask
  task automatic t_event;
  begin
    apb(1'b1, PAC_ADDR_CTRL, 8'h40);
    apb(1'b1, PAC_ADDR_COUNT, 8'hFE);
    burst(8'h04, 4'h2);
    rc(PAC_ADDR_COUNT, 8'h00);
    rc(PAC_ADDR_FLAG, 8'h30);
    chk_irq(1'b0);
    apb(1'b1, PAC_ADDR_MASK, 8'h30);
    chk_irq(1'b1);
    apb(1'b1, PAC_ADDR_FLAG, 8'h00);
    rc(PAC_ADDR_FLAG, 8'h30);
    apb(1'b1, PAC_ADDR_FLAG, 8'h10);
    rc(PAC_ADDR_FLAG, 8'h20);
    chk_irq(1'b1);
    apb(1'b1, PAC_ADDR_FLAG, 8'h20);
    rc(PAC_ADDR_FLAG, 8'h00);
    chk_irq(1'b0);
    rc(PAC_ADDR_IRQ, 8'h30);
    rc(PAC_ADDR_IRQ, 8'h00);
    apb(1'b1, PAC_ADDR_CTRL, 8'h50);
    apb(1'b1, PAC_ADDR_COUNT, 8'h10);
    burst(8'h03, 4'h5);
    rc(PAC_ADDR_COUNT, 8'h12);
  end
  endtask
  task automatic t_off;
  begin
    apb(1'b1, PAC_ADDR_FLAG, 8'h30);
    apb(1'b1, PAC_ADDR_CTRL, 8'h10);
    burst(8'h02, 4'h2);
    rc(PAC_ADDR_COUNT, 8'h12);
    rc(PAC_ADDR_FLAG, 8'h00);
  end
  endtask
  task automatic t_gated;
  begin
    apb(1'b1, PAC_ADDR_CTRL, 8'h60);
    apb(1'b1, PAC_ADDR_COUNT, 8'h00);
    repeat (40) @(posedge pclk);
    apb(1'b0, PAC_ADDR_COUNT, 8'h00);
    chk({31'h0000_0000, rd >= 9 && rd <= 12}, 32'h0000_0001);
    burst(8'h01, 4'h2);
    apb(1'b1, PAC_ADDR_COUNT, 8'h33);
    repeat (20) @(posedge pclk);
    rc(PAC_ADDR_COUNT, 8'h33);
    apb(1'b1, PAC_ADDR_CTRL, 8'h70);
    apb(1'b1, PAC_ADDR_COUNT, 8'h00);
    repeat (40) @(posedge pclk);
    apb(1'b0, PAC_ADDR_COUNT, 8'h00);
    chk({31'h0000_0000, rd >= 9 && rd <= 12}, 32'h0000_0001);
  end
  endtask
  // falling edge lands on the same edge as an edge-flag clear, then a freeze
  task automatic t_corner;
  begin
    apb(1'b1, PAC_ADDR_CTRL, 8'h40);
    burst(8'h01, 4'h2);
    apb(1'b1, PAC_ADDR_FLAG, 8'h30);
    apb(1'b1, PAC_ADDR_COUNT, 8'hFF);
    n_tgl <= 8'h01;
    half  <= 4'h2;
    go    <= 1'b1;
    @(posedge pclk);
    go    <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(1'b1, PAC_ADDR_FLAG, 8'h10);
    rc(PAC_ADDR_FLAG, 8'h30);
    rc(PAC_ADDR_COUNT, 8'h00);
    chk_irq(1'b1);
    ce <= 1'b0;
    burst(8'h02, 4'h2);
    ce <= 1'b1;
    rc(PAC_ADDR_COUNT, 8'h00);
    rc(PAC_ADDR_FLAG, 8'h30);
  end
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_event;
    t_off;
    t_gated;
    t_corner;
    results;
  end
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    results;
  end
endmodule
`default_nettype wire
